// File: shared/pipc_pkg.sv
package pipc_pkg;
	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_PIN_HI_EN   = 8'h84;
	localparam logic [7:0] IDX_PIN_HI_FLG  = 8'h85;
	localparam logic [7:0] IDX_TCTL        = 8'h88;
	localparam logic [7:0] IDX_MISC_FLG    = 8'h95;
	localparam logic [7:0] IDX_P1_WAKE     = 8'h96;
	localparam logic [7:0] IDX_MAIN_EN     = 8'ha8;
	localparam logic [7:0] IDX_AUX_EN      = 8'ha9;
	localparam logic [7:0] IDX_MAIN_PRI_LO = 8'hb8;
	localparam logic [7:0] IDX_MAIN_PRI_HI = 8'hb9;
	localparam logic [7:0] IDX_AUX_PRI_LO  = 8'hba;
	localparam logic [7:0] IDX_AUX_PRI_HI  = 8'hbb;
	localparam logic [7:0] RST_BYTE        = 8'h00;
	// Main enable fields
	localparam int MAIN_GLOBAL   = 7;
	localparam int MAIN_PIN1     = 2;
	localparam int MAIN_PIN0     = 0;
	localparam logic [7:0] MAIN_MASK = 8'hbf;
	localparam logic [7:0] MAIN_PRI_MASK = 8'h3f;
	// Aux enable fields
	localparam int AUX_SHARED    = 2;
	localparam int AUX_P1_IRQ    = 1;
	// Timer and pin control fields
	localparam int TC_TF1        = 7;
	localparam int TC_TF0        = 5;
	localparam int TC_TR1        = 6;
	localparam int TC_TR0        = 4;
	localparam int TC_PIN1_FLAG  = 3;
	localparam int TC_PIN1_TRIG  = 2;
	localparam int TC_PIN0_FLAG  = 1;
	localparam int TC_PIN0_TRIG  = 0;
	// Miscellaneous flag fields
	localparam int MF_LOW_VOLT   = 7;
	localparam int MF_TOUCH      = 5;
	localparam int MF_ADC        = 4;
	localparam int MF_P1_CHANGE  = 1;
	localparam int MF_TIMER3     = 0;
	localparam logic [7:0] MF_MASK      = 8'hb3;
	localparam logic [7:0] MF_LV_CLEAR  = 8'h7f;
	// Sources in vector order, lowest vector first
	localparam int NSRC          = 14;
	localparam logic [3:0] SRC_PIN0     = 4'h0;
	localparam logic [3:0] SRC_TIMER0   = 4'h1;
	localparam logic [3:0] SRC_PIN1     = 4'h2;
	localparam logic [3:0] SRC_TIMER1   = 4'h3;
	localparam logic [3:0] SRC_P1       = 4'h7;
	localparam int NPERIPH       = 6;
	localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
endpackage

// File: logic/pipc_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - Each source's level is its high bit and low bit; 11 is highest.
// - Main pair holds six classic sources; aux pair holds eight newer ones.
// - Global enable 0 blocks all; 1 lets individual enables decide.
// - Pin 0/1 enables gate interrupt and wake; wake ignores global enable.
// - Shared enable gates pins 2-9, their wake, and low-voltage interrupt.
// - Per-pin enables gate pins 9-2 only together with the shared enable.
// - Port1 interrupt enable gates only the request, never wake-up.
// - Port1 wake bits enable wake and change detection per pin.
// - Pin 0/1 trigger bit: 0 low level, 1 falling edge.
// - Pin 0/1 edge flags set on falling edge always; cleared on service.
// - Pins 9-2 edge flags set on falling edge; only software clears them.
// - Pins 2-9 fall-edge only; Port1 triggers on any change.
// - Port1 change flag set by enabled pin change; cleared on service.
// - Writing 0 clears a miscellaneous flag other than low-voltage; writing 1 leaves it.
// - Low-voltage flag is set by hardware, cleared only by writing 7Fh.
// - Halt is refused while an enabled pin 0-9 is low.
// - Aux enables gate UART2, SPI, ADC/touch and timer3 requests.
// - Pending request preempts only a strictly lower running level.
// - Pins 2-9 share one vector with the low-voltage interrupt.
// - Port1 wake does not enter service unless global and Port1 enables allow.
module pipc_ctrl (
	input  wire logic        CLK_SYS,
	input  wire logic        RSTN,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [9:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        EXT_PIN_0,
	input  wire logic        EXT_PIN_1,
	input  wire logic [7:0]  EXT_PINS_2_TO_9,
	input  wire logic [7:0]  PORT1_PINS,
	input  wire logic        LOW_VOLTAGE_DETECTOR,
	input  wire logic        TIMER0_OVF,
	input  wire logic        TIMER1_OVF,
	input  wire logic        TIMER3_OVF,
	input  wire logic        ADC_DONE,
	input  wire logic        TOUCH_DONE,
	input  wire logic [5:0]  PERIPH_REQ,
	input  wire logic        CORE_ACK,
	input  wire logic        CORE_RETI,
	output logic             IRQ_REQ,
	output logic      [3:0]  IRQ_VECTOR,
	output logic      [1:0]  IRQ_LEVEL,
	output logic             WAKEUP,
	output logic             HALT_BLOCK,
	output logic             TIMER0_RUN,
	output logic             TIMER1_RUN
);
	// ****************************************
	// Registers and synchronisers
	// ****************************************
	logic [7:0]  pins_9_to_2_enables;
	logic [7:0]  pins_9_to_2_edge_flags;
	logic [7:0]  tctl;
	logic [7:0]  misc_flg;
	logic [7:0]  port1_wake_enable_bits;
	logic [7:0]  main_en;
	logic [7:0]  aux_en;
	logic [7:0]  main_pri_lo;
	logic [7:0]  main_pri_hi;
	logic [7:0]  aux_pri_lo;
	logic [7:0]  aux_pri_hi;
	logic [3:0]  in_service;
	logic [18:0] pin_s1;
	logic [18:0] pin_s2;
	logic [18:0] pin_d;
	logic [18:0] pin_raw;

	assign pin_raw = {LOW_VOLTAGE_DETECTOR, PORT1_PINS, EXT_PINS_2_TO_9, EXT_PIN_1, EXT_PIN_0};

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			pin_s1 <= 19'h3_ffff;
			pin_s2 <= 19'h3_ffff;
			pin_d  <= 19'h3_ffff;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_d  <= pin_s2;
		end
	end

	logic       ext_pin_0;
	logic       ext_pin_1;
	logic [7:0] ext_pins_2_to_9;
	logic [7:0] port1_now;
	logic       fall_0;
	logic       fall_1;
	logic [7:0] fall_hi;
	logic [7:0] p1_change;
	logic       low_voltage_rise;

	assign ext_pin_0        = pin_s2[0];
	assign ext_pin_1        = pin_s2[1];
	assign ext_pins_2_to_9  = pin_s2[9:2];
	assign port1_now        = pin_s2[17:10];
	assign fall_0           = pin_d[0] & ~pin_s2[0];
	assign fall_1           = pin_d[1] & ~pin_s2[1];
	assign fall_hi          = pin_d[9:2] & ~pin_s2[9:2];
	assign p1_change        = (pin_d[17:10] ^ port1_now) & port1_wake_enable_bits;
	assign low_voltage_rise = pin_s2[18] & ~pin_d[18];

	// ****************************************
	// APB slave
	// ****************************************
	logic       setup_ph;
	logic       wr_en;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic       mapped;
	logic [7:0] rbyte;

	assign setup_ph = PSEL & ~PENABLE;
	assign wr_en    = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
	assign idx      = PADDR[9:2];
	assign wbyte    = PWDATA[7:0];

	always_comb
	begin
		mapped = 1'b1;
		rbyte  = pipc_pkg::RST_BYTE;
		unique case (idx)
			pipc_pkg::IDX_PIN_HI_EN:   rbyte = pins_9_to_2_enables;
			pipc_pkg::IDX_PIN_HI_FLG:  rbyte = pins_9_to_2_edge_flags;
			pipc_pkg::IDX_TCTL:        rbyte = tctl;
			pipc_pkg::IDX_MISC_FLG:    rbyte = misc_flg;
			pipc_pkg::IDX_P1_WAKE:     rbyte = port1_wake_enable_bits;
			pipc_pkg::IDX_MAIN_EN:     rbyte = main_en;
			pipc_pkg::IDX_AUX_EN:      rbyte = aux_en;
			pipc_pkg::IDX_MAIN_PRI_LO: rbyte = main_pri_lo;
			pipc_pkg::IDX_MAIN_PRI_HI: rbyte = main_pri_hi;
			pipc_pkg::IDX_AUX_PRI_LO:  rbyte = aux_pri_lo;
			pipc_pkg::IDX_AUX_PRI_HI:  rbyte = aux_pri_hi;
			default:                   mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA  <= pipc_pkg::WORD_ZERO;
		end
		else
		begin
			PREADY  <= setup_ph;
			PSLVERR <= setup_ph & ~mapped;
			if (setup_ph)
				PRDATA <= {24'h00_0000, rbyte};
		end
	end

	function automatic logic wr_hit(input logic [7:0] target);
		return wr_en && idx == target;
	endfunction

	// ****************************************
	// Plain control registers
	// ****************************************
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			pins_9_to_2_enables    <= pipc_pkg::RST_BYTE;
			port1_wake_enable_bits <= pipc_pkg::RST_BYTE;
			main_en                <= pipc_pkg::RST_BYTE;
			aux_en                 <= pipc_pkg::RST_BYTE;
			main_pri_lo            <= pipc_pkg::RST_BYTE;
			main_pri_hi            <= pipc_pkg::RST_BYTE;
			aux_pri_lo             <= pipc_pkg::RST_BYTE;
			aux_pri_hi             <= pipc_pkg::RST_BYTE;
		end
		else
		begin
			if (wr_hit(pipc_pkg::IDX_PIN_HI_EN))
				pins_9_to_2_enables <= wbyte;
			if (wr_hit(pipc_pkg::IDX_P1_WAKE))
				port1_wake_enable_bits <= wbyte;
			if (wr_hit(pipc_pkg::IDX_MAIN_EN))
				main_en <= wbyte & pipc_pkg::MAIN_MASK;
			if (wr_hit(pipc_pkg::IDX_AUX_EN))
				aux_en <= wbyte;
			if (wr_hit(pipc_pkg::IDX_MAIN_PRI_LO))
				main_pri_lo <= wbyte & pipc_pkg::MAIN_PRI_MASK;
			if (wr_hit(pipc_pkg::IDX_MAIN_PRI_HI))
				main_pri_hi <= wbyte & pipc_pkg::MAIN_PRI_MASK;
			if (wr_hit(pipc_pkg::IDX_AUX_PRI_LO))
				aux_pri_lo <= wbyte;
			if (wr_hit(pipc_pkg::IDX_AUX_PRI_HI))
				aux_pri_hi <= wbyte;
		end
	end

	// ****************************************
	// Flags, set wins over clear
	// ****************************************
	logic       ack_now;
	logic [3:0] ack_vec;

	assign ack_now = CORE_ACK & IRQ_REQ;
	assign ack_vec = IRQ_VECTOR;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			pins_9_to_2_edge_flags <= pipc_pkg::RST_BYTE;
		else if (wr_hit(pipc_pkg::IDX_PIN_HI_FLG))
			pins_9_to_2_edge_flags <= (pins_9_to_2_edge_flags & wbyte) | fall_hi;
		else
			pins_9_to_2_edge_flags <= pins_9_to_2_edge_flags | fall_hi;
	end

	logic [7:0] tctl_base;
	logic [7:0] tctl_set;
	logic [7:0] tctl_clr;

	always_comb
	begin
		tctl_base = wr_hit(pipc_pkg::IDX_TCTL) ? wbyte : tctl;
		tctl_set  = 8'h00;
		tctl_clr  = 8'h00;
		tctl_set[pipc_pkg::TC_PIN0_FLAG] = fall_0;
		tctl_set[pipc_pkg::TC_PIN1_FLAG] = fall_1;
		tctl_set[pipc_pkg::TC_TF0]       = TIMER0_OVF;
		tctl_set[pipc_pkg::TC_TF1]       = TIMER1_OVF;
		if (ack_now)
		begin
			tctl_clr[pipc_pkg::TC_PIN0_FLAG] = ack_vec == pipc_pkg::SRC_PIN0;
			tctl_clr[pipc_pkg::TC_PIN1_FLAG] = ack_vec == pipc_pkg::SRC_PIN1;
			tctl_clr[pipc_pkg::TC_TF0]       = ack_vec == pipc_pkg::SRC_TIMER0;
			tctl_clr[pipc_pkg::TC_TF1]       = ack_vec == pipc_pkg::SRC_TIMER1;
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			tctl <= pipc_pkg::RST_BYTE;
		else
			tctl <= (tctl_base & ~tctl_clr) | tctl_set;
	end

	logic [7:0] misc_keep;
	logic [7:0] misc_set;

	always_comb
	begin
		misc_keep = misc_flg;
		if (wr_hit(pipc_pkg::IDX_MISC_FLG))
		begin
			misc_keep = misc_flg & wbyte;
			misc_keep[pipc_pkg::MF_LOW_VOLT] = misc_flg[pipc_pkg::MF_LOW_VOLT]
				& (wbyte != pipc_pkg::MF_LV_CLEAR);
		end
		if (ack_now && ack_vec == pipc_pkg::SRC_P1)
			misc_keep[pipc_pkg::MF_P1_CHANGE] = 1'b0;
		misc_set = 8'h00;
		misc_set[pipc_pkg::MF_LOW_VOLT]  = low_voltage_rise;
		misc_set[pipc_pkg::MF_TOUCH]     = TOUCH_DONE;
		misc_set[pipc_pkg::MF_ADC]       = ADC_DONE;
		misc_set[pipc_pkg::MF_P1_CHANGE] = |p1_change;
		misc_set[pipc_pkg::MF_TIMER3]    = TIMER3_OVF;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			misc_flg <= pipc_pkg::RST_BYTE;
		else
			misc_flg <= (misc_keep | misc_set) & pipc_pkg::MF_MASK;
	end

	// ****************************************
	// Source requests and levels
	// ****************************************
	logic [pipc_pkg::NSRC-1:0] raw_req;
	logic [pipc_pkg::NSRC-1:0] src_en;
	logic [pipc_pkg::NSRC-1:0] pend;
	logic [pipc_pkg::NSRC-1:0] pri_hi;
	logic [pipc_pkg::NSRC-1:0] pri_lo;
	logic                      pin0_req;
	logic                      pin1_req;
	logic                      shared_req;

	assign pin0_req = tctl[pipc_pkg::TC_PIN0_TRIG] ? tctl[pipc_pkg::TC_PIN0_FLAG]
		: ~ext_pin_0;
	assign pin1_req = tctl[pipc_pkg::TC_PIN1_TRIG] ? tctl[pipc_pkg::TC_PIN1_FLAG]
		: ~ext_pin_1;
	assign shared_req = |(pins_9_to_2_edge_flags & pins_9_to_2_enables)
		| misc_flg[pipc_pkg::MF_LOW_VOLT];

	// Vector order: pin0 t0 pin1 t1 uart1 t2 t3 p1 shared adc spi uart2 i2c pwm
	assign raw_req = {PERIPH_REQ[5:2],
		misc_flg[pipc_pkg::MF_ADC] | misc_flg[pipc_pkg::MF_TOUCH],
		shared_req, misc_flg[pipc_pkg::MF_P1_CHANGE], misc_flg[pipc_pkg::MF_TIMER3],
		PERIPH_REQ[1:0], tctl[pipc_pkg::TC_TF1], pin1_req,
		tctl[pipc_pkg::TC_TF0], pin0_req};
	assign src_en  = {aux_en[7:3], aux_en[2:0], main_en[5:0]};
	assign pri_hi  = {aux_pri_hi[7:3], aux_pri_hi[2], aux_pri_hi[1], aux_pri_hi[0],
		main_pri_hi[5:0]};
	assign pri_lo  = {aux_pri_lo[7:3], aux_pri_lo[2], aux_pri_lo[1], aux_pri_lo[0],
		main_pri_lo[5:0]};
	assign pend    = raw_req & src_en & {pipc_pkg::NSRC{main_en[pipc_pkg::MAIN_GLOBAL]}};

	// ****************************************
	// Arbitration
	// ****************************************
	logic       found;
	logic [3:0] best_vec;
	logic [1:0] best_lvl;
	logic [1:0] src_lvl;
	logic       preempt_ok;
	logic [1:0] run_lvl;

	always_comb
	begin
		found    = 1'b0;
		best_vec = 4'h0;
		best_lvl = 2'b00;
		src_lvl  = 2'b00;
		for (int i = pipc_pkg::NSRC - 1; i >= 0; i--)
		begin
			src_lvl = {pri_hi[i], pri_lo[i]};
			if (pend[i] && (!found || src_lvl >= best_lvl))
			begin
				found    = 1'b1;
				best_vec = 4'(i);
				best_lvl = src_lvl;
			end
		end
	end

	always_comb
	begin
		run_lvl = 2'b00;
		for (int l = 0; l < 4; l++)
			if (in_service[l])
				run_lvl = 2'(l);
		preempt_ok = (in_service == 4'h0) || (best_lvl > run_lvl);
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			IRQ_REQ    <= 1'b0;
			IRQ_VECTOR <= 4'h0;
			IRQ_LEVEL  <= 2'b00;
		end
		else
		begin
			IRQ_REQ    <= found & preempt_ok & ~ack_now;
			IRQ_VECTOR <= best_vec;
			IRQ_LEVEL  <= best_lvl;
		end
	end

	// Nesting by level; return ends the highest running level
	logic [3:0] top_bit;

	always_comb
	begin
		top_bit = 4'h0;
		for (int l = 0; l < 4; l++)
			if (in_service[l])
				top_bit = 4'h1 << l;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			in_service <= 4'h0;
		else if (ack_now)
			in_service <= in_service | (4'h1 << IRQ_LEVEL);
		else if (CORE_RETI)
			in_service <= in_service & ~top_bit;
	end

	// ****************************************
	// Wake-up and halt refusal
	// ****************************************
	logic       low_0;
	logic       low_1;
	logic [7:0] low_hi;
	logic       hi_gate;

	assign hi_gate = aux_en[pipc_pkg::AUX_SHARED];
	assign low_0   = main_en[pipc_pkg::MAIN_PIN0] & ~ext_pin_0;
	assign low_1   = main_en[pipc_pkg::MAIN_PIN1] & ~ext_pin_1;
	assign low_hi  = pins_9_to_2_enables & ~ext_pins_2_to_9 & {8{hi_gate}};

	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
		begin
			WAKEUP     <= 1'b0;
			HALT_BLOCK <= 1'b0;
			TIMER0_RUN <= 1'b0;
			TIMER1_RUN <= 1'b0;
		end
		else
		begin
			WAKEUP     <= low_0 | low_1 | (|low_hi) | (|p1_change);
			HALT_BLOCK <= low_0 | low_1 | (|low_hi);
			TIMER0_RUN <= tctl[pipc_pkg::TC_TR0];
			TIMER1_RUN <= tctl[pipc_pkg::TC_TR1];
		end
	end
endmodule

// File: tb/pipc_ctrl_props.sv
`timescale 1ns/1ps
// ****
// Checker
// ****
module pipc_ctrl_props (
	input wire logic		CLK_SYS,
	input wire logic		RSTN,
	input wire logic		PSEL,
	input wire logic		PENABLE,
	input wire logic		PWRITE,
	input wire logic [9:0]	PADDR,
	input wire logic [31:0]	PWDATA,
	input wire logic [31:0]	PRDATA,
	input wire logic		PREADY,
	input wire logic		PSLVERR,
	input wire logic		EXT_PIN_0,
	input wire logic		EXT_PIN_1,
	input wire logic [7:0]	EXT_PINS_2_TO_9,
	input wire logic [7:0]	PORT1_PINS,
	input wire logic		CORE_ACK,
	input wire logic		IRQ_REQ,
	input wire logic [1:0]	IRQ_LEVEL,
	input wire logic		WAKEUP,
	input wire logic		HALT_BLOCK,
	input wire logic		TIMER0_RUN,
	input wire logic		TIMER1_RUN
);
	logic				ea;
	wire logic			acc = PSEL && PENABLE && PREADY;
	wire logic [7:0]	ix = PADDR[9:2];
	wire logic			hit = ix inside {[8'h84:8'h85], 8'h88, [8'h95:8'h96],
		[8'ha8:8'ha9], [8'hb8:8'hbb]};
	wire logic			hi = EXT_PIN_0 && EXT_PIN_1 && (&EXT_PINS_2_TO_9);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	// Shadow of the global enable
	always_ff @(posedge CLK_SYS)
	begin
		if (!RSTN)
			ea <= 1'b0;
		else if (acc && PWRITE && ix == pipc_pkg::IDX_MAIN_EN)
			ea <= PWDATA[pipc_pkg::MAIN_GLOBAL];
	end
	AST_RDY: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	AST_RDY1: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	AST_ERR: assert property (PSEL && !PENABLE |=> PSLVERR == !$past(hit))
		else $error("slave error wrong");
	AST_HI: assert property (PREADY |-> PRDATA[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	AST_TRUN: assert property (acc && PWRITE && ix == pipc_pkg::IDX_TCTL |-> ##2
		TIMER0_RUN == $past(PWDATA[4], 2) && TIMER1_RUN == $past(PWDATA[6], 2))
		else $error("timer run bits wrong");
	AST_EA: assert property (!ea && !$past(ea) |-> !IRQ_REQ)
		else $error("request with global enable off");
	AST_PRE: assert property (IRQ_REQ && CORE_ACK |-> ##2
		!IRQ_REQ || IRQ_LEVEL > $past(IRQ_LEVEL, 2))
		else $error("request not above running level");
	AST_HALT: assert property (hi [*6] |=> !HALT_BLOCK)
		else $error("halt refused with pins high");
	AST_WAKE: assert property ((hi && $stable(PORT1_PINS)) [*8] |=> !WAKEUP)
		else $error("wake without cause");
	cover property (IRQ_REQ && CORE_ACK);
	cover property (HALT_BLOCK);
	cover property (WAKEUP);
	cover property (PSLVERR);
endmodule

bind pipc_ctrl pipc_ctrl_props u_props (.CLK_SYS, .RSTN, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EXT_PIN_0, .EXT_PIN_1,
	.EXT_PINS_2_TO_9, .PORT1_PINS, .CORE_ACK, .IRQ_REQ, .IRQ_LEVEL, .WAKEUP,
	.HALT_BLOCK, .TIMER0_RUN, .TIMER1_RUN);

// File: tb/pipc_core_model.sv
`timescale 1ns/1ps
// ****
// Core model
// ****
module pipc_core_model (
	input wire logic		clk,
	input wire logic		rst_n,
	input wire logic		irq_req,
	input wire logic [3:0]	irq_vector,
	input wire logic		ack_en,
	input wire logic		do_reti,
	output logic			core_ack,
	output logic			core_reti,
	output logic [3:0]		last_vec
);
	// One acknowledge per window; silent while ack_en is low
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			core_ack <= 1'b0;
			core_reti <= 1'b0;
			last_vec <= 4'h0;
		end
		else
		begin
			core_ack <= ack_en && irq_req && !core_ack;
			core_reti <= do_reti;
			if (core_ack && irq_req)
				last_vec <= irq_vector;
		end
	end
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
// ****
// Bench
// ****
module testbench;
	logic			CLK_SYS = 1'b0;
	logic			RSTN = 1'b0;
	logic			PSEL = 1'b0;
	logic			PENABLE = 1'b0;
	logic			PWRITE = 1'b0;
	logic [9:0]		PADDR = 10'h000;
	logic [31:0]	PWDATA = 32'h0000_0000;
	logic			EXT_PIN_0 = 1'b1;
	logic			EXT_PIN_1 = 1'b1;
	logic [7:0]		EXT_PINS_2_TO_9 = 8'hff;
	logic [7:0]		PORT1_PINS = 8'hff;
	logic			LOW_VOLTAGE_DETECTOR = 1'b0;
	logic			TIMER0_OVF = 1'b0;
	logic			TIMER1_OVF = 1'b0;
	logic			TIMER3_OVF = 1'b0;
	logic			ADC_DONE = 1'b0;
	logic			TOUCH_DONE = 1'b0;
	logic [5:0]		PERIPH_REQ = 6'h00;
	logic			ack_en = 1'b0;
	logic			do_reti = 1'b0;
	logic			wk_seen = 1'b0;
	logic			wk_clr = 1'b0;
	logic [31:0]	PRDATA;
	logic			PREADY, PSLVERR, IRQ_REQ, WAKEUP, HALT_BLOCK;
	logic			TIMER0_RUN, TIMER1_RUN, CORE_ACK, CORE_RETI, er;
	logic [3:0]		IRQ_VECTOR, last_vec;
	logic [1:0]		IRQ_LEVEL;
	logic [31:0]	q;
	int				err_count = 0;
	int				total_checks = 0;
	int				cyc = 0;
	logic [7:0]		ri [9] = '{8'h84, 8'h88, 8'h96, 8'ha8, 8'ha9, 8'hb8, 8'hb9, 8'hba, 8'hbb};
	logic [7:0]		rm [9] = '{8'hff, 8'hff, 8'hff, 8'hbf, 8'hff, 8'h3f, 8'h3f, 8'hff, 8'hff};

	pipc_ctrl dut (.CLK_SYS, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .EXT_PIN_0, .EXT_PIN_1, .EXT_PINS_2_TO_9, .PORT1_PINS,
		.LOW_VOLTAGE_DETECTOR, .TIMER0_OVF, .TIMER1_OVF, .TIMER3_OVF, .ADC_DONE,
		.TOUCH_DONE, .PERIPH_REQ, .CORE_ACK, .CORE_RETI, .IRQ_REQ, .IRQ_VECTOR,
		.IRQ_LEVEL, .WAKEUP, .HALT_BLOCK, .TIMER0_RUN, .TIMER1_RUN);
	pipc_core_model u_core (.clk(CLK_SYS), .rst_n(RSTN), .irq_req(IRQ_REQ),
		.irq_vector(IRQ_VECTOR), .ack_en, .do_reti, .core_ack(CORE_ACK),
		.core_reti(CORE_RETI), .last_vec);

	initial
		forever #20 CLK_SYS = ~CLK_SYS;

	always @(posedge CLK_SYS)
	begin
		cyc <= cyc + 1;
		if (wk_clr)
			wk_seen <= 1'b0;
		else if (WAKEUP === 1'b1)
			wk_seen <= 1'b1;
		if (cyc == 5000)
		begin
			err_count++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic tk(input int n);
		repeat (n) @(posedge CLK_SYS);
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic ap(input logic w, input logic [7:0] i, input logic [7:0] d);
		tk(1);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= {i, 2'b00};
		PWDATA <= {24'h00_0000, d};
		tk(1);
		PENABLE <= 1'b1;
		do
			tk(1);
		while (PREADY !== 1'b1);
		q = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		ap(1'b1, i, d);
	endtask

	task automatic rd(input logic [7:0] i, input logic [7:0] e);
		ap(1'b0, i, 8'h00);
		chk($sformatf("reg %h", i), e, q[7:0]);
	endtask

	task automatic irq(input logic [3:0] v);
		chk("req", 8'h01, IRQ_REQ);
		chk("vec", v, IRQ_VECTOR);
	endtask

	task automatic ack;
		ack_en <= 1'b1;
		do
			tk(1);
		while (CORE_ACK !== 1'b1);
		ack_en <= 1'b0;
	endtask

	task automatic reti;
		do_reti <= 1'b1;
		tk(1);
		do_reti <= 1'b0;
		tk(4);
	endtask

	task automatic svc;
		ack();
		reti();
	endtask

	initial
	begin
		tk(6);
		RSTN <= 1'b1;
		tk(3);
		rd(8'h85, 8'h00);
		rd(8'h95, 8'h00);
		for (int k = 0; k < 9; k++)
		begin
			rd(ri[k], 8'h00);
			wr(ri[k], 8'hff);
			rd(ri[k], rm[k]);
			wr(ri[k], 8'h00);
		end
		ap(1'b0, 8'h00, 8'h00);
		chk("slverr", 8'h01, er);
		chk("rdata", 8'h00, q[7:0]);
		wr(8'h88, 8'h50);
		tk(2);
		chk("run0", 8'h01, TIMER0_RUN);
		chk("run1", 8'h01, TIMER1_RUN);
		wr(8'h88, 8'h00);
		tk(2);
		chk("run0", 8'h00, TIMER0_RUN);
		// ****
		// Priority and nesting
		// ****
		wr(8'ha8, 8'h8a);
		TIMER0_OVF <= 1'b1;
		TIMER1_OVF <= 1'b1;
		tk(1);
		TIMER0_OVF <= 1'b0;
		TIMER1_OVF <= 1'b0;
		tk(3);
		irq(pipc_pkg::SRC_TIMER0);
		chk("lvl", 8'h00, IRQ_LEVEL);
		wr(8'hb9, 8'h08);
		wr(8'hb8, 8'h08);
		tk(2);
		irq(pipc_pkg::SRC_TIMER1);
		chk("lvl", 8'h03, IRQ_LEVEL);
		ack();
		tk(1);
		chk("req", 8'h00, IRQ_REQ);
		chk("acked", pipc_pkg::SRC_TIMER1, last_vec);
		rd(8'h88, 8'h20);
		reti();
		irq(pipc_pkg::SRC_TIMER0);
		svc();
		// ****
		// Enables
		// ****
		wr(8'ha8, 8'h02);
		TIMER0_OVF <= 1'b1;
		tk(1);
		TIMER0_OVF <= 1'b0;
		tk(5);
		chk("req", 8'h00, IRQ_REQ);
		wr(8'ha8, 8'h82);
		tk(2);
		irq(pipc_pkg::SRC_TIMER0);
		svc();
		PERIPH_REQ <= 6'h08;
		tk(4);
		chk("req", 8'h00, IRQ_REQ);
		wr(8'ha9, 8'h20);
		tk(2);
		irq(4'hb);
		PERIPH_REQ <= 6'h00;
		wr(8'ha9, 8'h00);
		// ****
		// Pin 0
		// ****
		wr(8'ha8, 8'h80);
		wr(8'h88, 8'h01);
		EXT_PIN_0 <= 1'b0;
		tk(5);
		rd(8'h88, 8'h03);
		chk("req", 8'h00, IRQ_REQ);
		chk("halt", 8'h00, HALT_BLOCK);
		wr(8'ha8, 8'h81);
		tk(2);
		irq(pipc_pkg::SRC_PIN0);
		chk("halt", 8'h01, HALT_BLOCK);
		chk("wake", 8'h01, WAKEUP);
		svc();
		rd(8'h88, 8'h01);
		chk("req", 8'h00, IRQ_REQ);
		wr(8'h88, 8'h00);
		tk(2);
		irq(pipc_pkg::SRC_PIN0);
		wr(8'ha8, 8'h01);
		tk(2);
		chk("req", 8'h00, IRQ_REQ);
		chk("wake", 8'h01, WAKEUP);
		EXT_PIN_0 <= 1'b1;
		wr(8'ha8, 8'h00);
		tk(4);
		// ****
		// Pins 2 to 9
		// ****
		wr(8'h84, 8'h01);
		EXT_PINS_2_TO_9 <= 8'hfe;
		tk(5);
		rd(8'h85, 8'h01);
		chk("halt", 8'h00, HALT_BLOCK);
		wr(8'ha9, 8'h04);
		tk(2);
		chk("halt", 8'h01, HALT_BLOCK);
		wr(8'ha8, 8'h80);
		tk(2);
		irq(4'h8);
		svc();
		rd(8'h85, 8'h01);
		wr(8'h85, 8'hff);
		rd(8'h85, 8'h01);
		wr(8'h85, 8'hfe);
		rd(8'h85, 8'h00);
		chk("req", 8'h00, IRQ_REQ);
		EXT_PINS_2_TO_9 <= 8'hff;
		tk(5);
		rd(8'h85, 8'h00);
		wr(8'h84, 8'h00);
		// ****
		// Port1 change
		// ****
		wr(8'h96, 8'h01);
		wk_clr <= 1'b1;
		tk(1);
		wk_clr <= 1'b0;
		PORT1_PINS <= 8'hfd;
		tk(6);
		rd(8'h95, 8'h00);
		chk("wake", 8'h00, wk_seen);
		PORT1_PINS <= 8'hfc;
		tk(6);
		rd(8'h95, 8'h02);
		chk("wake", 8'h01, wk_seen);
		chk("req", 8'h00, IRQ_REQ);
		wr(8'h95, 8'hff);
		rd(8'h95, 8'h02);
		wr(8'h95, 8'hfd);
		rd(8'h95, 8'h00);
		wr(8'ha9, 8'h06);
		PORT1_PINS <= 8'hfd;
		tk(6);
		irq(pipc_pkg::SRC_P1);
		svc();
		rd(8'h95, 8'h00);
		// ****
		// Low voltage
		// ****
		LOW_VOLTAGE_DETECTOR <= 1'b1;
		tk(6);
		rd(8'h95, 8'h80);
		wr(8'h95, 8'h00);
		rd(8'h95, 8'h80);
		wr(8'h95, 8'h7f);
		rd(8'h95, 8'h00);
		end_sim();
	end
endmodule
